// ===== shared/hrlpc_pkg.sv
package hrlpc_pkg;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS  = 10;
	localparam int unsigned POR_TIME_US    = 10;
	localparam int unsigned POR_CYCLES     = (POR_TIME_US * 1000) / CLK_PERIOD_NS;
	localparam int unsigned STABLE_TIME_US = 5;
	localparam int unsigned STABLE_CYCLES  = (STABLE_TIME_US * 1000) / CLK_PERIOD_NS;
	localparam int unsigned L2_ENTRY_US    = 3000;
	localparam int unsigned L2_ENTRY_CYC   = (L2_ENTRY_US * 1000) / CLK_PERIOD_NS;
	localparam int unsigned L2_EXIT_US     = 2000;
	localparam int unsigned L2_EXIT_CYC    = (L2_EXIT_US * 1000) / CLK_PERIOD_NS;
	// least-below limits: use one cycle under the bound
	localparam int unsigned L1_ENTRY_US    = 10;
	localparam int unsigned L1_ENTRY_CYC   = (L1_ENTRY_US * 1000) / CLK_PERIOD_NS - 1;
	localparam int unsigned L1_EXIT_US     = 50;
	localparam int unsigned L1_EXIT_CYC    = (L1_EXIT_US * 1000) / CLK_PERIOD_NS - 1;

	// ------------------------------------------------------------
	// values after reset and counter width
	// ------------------------------------------------------------
	localparam logic [6:0] DEFAULT_ADDR   = 7'h00;
	localparam logic [7:0] UNCONFIGURED   = 8'h00;
	localparam int unsigned CNT_W         = 32;

	typedef enum logic [2:0] {
		LPS_L0,
		LPS_L1_ENTER,
		LPS_L1,
		LPS_L1_EXIT,
		LPS_L2_ENTER,
		LPS_L2,
		LPS_L2_EXIT
	} hrlpc_lps_type;

	typedef enum logic [1:0] {
		LINK_L0 = 2'h0,
		LINK_L1 = 2'h1,
		LINK_L2 = 2'h2
	} hrlpc_link_type;

endpackage

// ===== verilog/hrlpc_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser; first stage is read only by the second
module hrlpc_sync
(
	input  wire logic i_clk,
	input  wire logic i_d,
	output logic      o_q
);
	logic meta_ff;

	always_ff @(posedge i_clk)
	begin
		meta_ff <= i_d;
		o_q     <= meta_ff;
	end
endmodule

// ===== verilog/hrlpc_top.sv
`timescale 1ns/1ps
module hrlpc_top
	import hrlpc_pkg::*;
#(
	parameter int unsigned POR_CNT      = POR_CYCLES,
	parameter int unsigned STABLE_CNT   = STABLE_CYCLES,
	parameter int unsigned L2_ENTRY_CNT = L2_ENTRY_CYC,
	parameter int unsigned L2_EXIT_CNT  = L2_EXIT_CYC
)
(
	// clock and power-on reset
	input  wire logic           i_clk,
	input  wire logic           i_rst_n,
	// external reset pin (asynchronous)
	input  wire logic           i_ext_reset_n,
	// upstream bus events (same clock domain)
	input  wire logic           i_bus_reset,
	input  wire logic           i_set_addr,
	input  wire logic [6:0]     i_addr,
	input  wire logic           i_set_config,
	input  wire logic [7:0]     i_config,
	// link power requests (same clock domain)
	input  wire logic           i_l1_req,
	input  wire logic           i_l2_req,
	input  wire logic           i_resume,
	// clock generation and reset outputs
	output logic                o_osc_en,
	output logic                o_pll_en,
	output logic                o_core_rst_n,
	output logic                o_standby,
	// transceiver control
	output logic                o_phy_en,
	output logic                o_dp_oe,
	output logic                o_xact_abort,
	// device state
	output logic [6:0]          o_addr,
	output logic [7:0]          o_config,
	output logic                o_configured,
	output logic                o_suspended,
	output logic                o_dn_reset,
	// link state
	output hrlpc_link_type      o_link_state,
	output logic                o_link_busy
);
	import hrlpc_pkg::*;

	// ------------------------------------------------------------
	// external pin synchronisation
	// ------------------------------------------------------------
	logic ext_n_sync;
	hrlpc_sync u_ext_sync
	(
		.i_clk (i_clk),
		.i_d   (i_ext_reset_n),
		.o_q   (ext_n_sync)
	);

	// ------------------------------------------------------------
	// power-on timer and clock stability
	// ------------------------------------------------------------
	logic [CNT_W-1:0] por_cnt_ff;
	logic             por_done_ff;
	logic [CNT_W-1:0] stab_cnt_ff;
	logic             rel_ok;
	logic             core_run;

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			por_cnt_ff  <= '0;
			por_done_ff <= 1'b0;
		end
		else if (!por_done_ff)
		begin
			por_cnt_ff  <= por_cnt_ff + 1'b1;
			por_done_ff <= (por_cnt_ff >= CNT_W'(POR_CNT - 1));
		end
	end

	// oscillator and pll stop while pin is low; stability count restarts on release
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			o_osc_en    <= 1'b0;
			o_pll_en    <= 1'b0;
			stab_cnt_ff <= '0;
		end
		else
		begin
			o_osc_en <= ext_n_sync;
			o_pll_en <= ext_n_sync;
			if (!ext_n_sync)
				stab_cnt_ff <= '0;
			else if (stab_cnt_ff < CNT_W'(STABLE_CNT))
				stab_cnt_ff <= stab_cnt_ff + 1'b1;
		end
	end

	assign rel_ok = ext_n_sync && (stab_cnt_ff >= CNT_W'(STABLE_CNT)) && por_done_ff;

	// assert as soon as the synchronised pin goes low, release only after stability
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			o_core_rst_n <= 1'b0;
			o_standby    <= 1'b1;
		end
		else
		begin
			o_core_rst_n <= rel_ok;
			o_standby    <= !ext_n_sync;
		end
	end

	assign core_run = o_core_rst_n && rel_ok;

	// ------------------------------------------------------------
	// transceiver and transaction control
	// ------------------------------------------------------------
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			o_phy_en     <= 1'b0;
			o_dp_oe      <= 1'b0;
			o_xact_abort <= 1'b1;
		end
		else
		begin
			o_phy_en     <= core_run;
			o_dp_oe      <= core_run && (o_link_state == LINK_L0);
			o_xact_abort <= !core_run;
		end
	end

	// ------------------------------------------------------------
	// device address and configuration
	// ------------------------------------------------------------
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n || !core_run)
		begin
			o_addr       <= DEFAULT_ADDR;
			o_config     <= UNCONFIGURED;
			o_configured <= 1'b0;
		end
		else if (i_bus_reset)
		begin
			o_addr       <= DEFAULT_ADDR;
			o_config     <= UNCONFIGURED;
			o_configured <= 1'b0;
		end
		else
		begin
			if (i_set_addr)
				o_addr <= i_addr;
			if (i_set_config)
			begin
				o_config     <= i_config;
				o_configured <= (i_config != UNCONFIGURED);
			end
		end
	end

	// bus reset is absorbed here; downstream reset line is raised only while core_run is low
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			o_dn_reset <= 1'b0;
		else
			o_dn_reset <= !core_run;
	end

	// ------------------------------------------------------------
	// link power state machine
	// ------------------------------------------------------------
	hrlpc_lps_type    lps_ff;
	logic [CNT_W-1:0] lcnt_ff;
	logic             lcnt_hit;
	logic [CNT_W-1:0] lcnt_lim;

	always_comb
	begin
		unique case (lps_ff)
			LPS_L1_ENTER: lcnt_lim = CNT_W'(L1_ENTRY_CYC);
			LPS_L1_EXIT:  lcnt_lim = CNT_W'(L1_EXIT_CYC);
			LPS_L2_ENTER: lcnt_lim = CNT_W'(L2_ENTRY_CNT);
			LPS_L2_EXIT:  lcnt_lim = CNT_W'(L2_EXIT_CNT);
			default:      lcnt_lim = '0;
		endcase
	end

	assign lcnt_hit = (lcnt_ff >= lcnt_lim - 1'b1);

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n || !core_run)
		begin
			lps_ff  <= LPS_L0;
			lcnt_ff <= '0;
		end
		else if (i_bus_reset)
		begin
			lps_ff  <= LPS_L0;
			lcnt_ff <= '0;
		end
		else
		begin
			lcnt_ff <= lcnt_ff + 1'b1;
			unique case (lps_ff)
				LPS_L0:
				begin
					lcnt_ff <= '0;
					if (i_l2_req)
						lps_ff <= LPS_L2_ENTER;
					else if (i_l1_req)
						lps_ff <= LPS_L1_ENTER;
				end
				LPS_L1_ENTER:
					if (lcnt_hit)
						lps_ff <= LPS_L1;
				LPS_L1:
				begin
					lcnt_ff <= '0;
					if (i_resume)
						lps_ff <= LPS_L1_EXIT;
				end
				LPS_L1_EXIT:
					if (lcnt_hit)
						lps_ff <= LPS_L0;
				LPS_L2_ENTER:
					if (lcnt_hit)
						lps_ff <= LPS_L2;
				LPS_L2:
				begin
					lcnt_ff <= '0;
					if (i_resume)
						lps_ff <= LPS_L2_EXIT;
				end
				LPS_L2_EXIT:
					if (lcnt_hit)
						lps_ff <= LPS_L0;
			endcase
			if (lps_ff != LPS_L0 && lcnt_hit && lps_ff != LPS_L1 && lps_ff != LPS_L2)
				lcnt_ff <= '0;
		end
	end

	// visible link state; transitions report the state being left
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n || !core_run)
		begin
			o_link_state <= LINK_L0;
			o_link_busy  <= 1'b0;
			o_suspended  <= 1'b0;
		end
		else
		begin
			o_link_busy <= !(lps_ff inside {LPS_L0, LPS_L1, LPS_L2});
			o_suspended <= (lps_ff == LPS_L2);
			unique case (lps_ff)
				LPS_L1, LPS_L1_EXIT: o_link_state <= LINK_L1;
				LPS_L2, LPS_L2_EXIT: o_link_state <= LINK_L2;
				default:             o_link_state <= LINK_L0;
			endcase
		end
	end

endmodule

// ===== dv/hrlpc_sva.sv
`timescale 1ns/1ps
module hrlpc_sva
	import hrlpc_pkg::*;
#(
	parameter int unsigned POR_CNT      = 8,
	parameter int unsigned STABLE_CNT   = 4,
	parameter int unsigned L2_ENTRY_CNT = 16,
	parameter int unsigned L2_EXIT_CNT  = 12
)
(
	input wire logic           i_clk,
	input wire logic           i_rst_n,
	input wire logic           i_ext_reset_n,
	input wire logic           i_bus_reset,
	input wire logic           i_l1_req,
	input wire logic           i_l2_req,
	input wire logic           o_osc_en,
	input wire logic           o_pll_en,
	input wire logic           o_core_rst_n,
	input wire logic           o_standby,
	input wire logic           o_phy_en,
	input wire logic           o_dp_oe,
	input wire logic           o_xact_abort,
	input wire logic [6:0]     o_addr,
	input wire logic [7:0]     o_config,
	input wire logic           o_configured,
	input wire logic           o_suspended,
	input wire logic           o_dn_reset,
	input wire hrlpc_link_type o_link_state,
	input wire logic           o_link_busy
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// sleep entry counted from the accepted request; bus or pin reset abandons it
	logic        s_pend_ff;
	logic [15:0] s_cnt_ff;
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n || !o_core_rst_n || i_bus_reset || o_link_state == LINK_L1)
		begin
			s_pend_ff <= 1'b0;
			s_cnt_ff  <= '0;
		end
		else
		begin
			if (i_l1_req && !i_l2_req && o_link_state == LINK_L0 && !o_link_busy)
				s_pend_ff <= 1'b1;
			if (s_pend_ff)
				s_cnt_ff <= s_cnt_ff + 16'h1;
		end
	end
	// sleep exit outlasts a delay range, so it is counted here
	logic [15:0] x_cnt_ff;
	always_ff @(posedge i_clk)
		if (!i_rst_n || !(o_link_busy && o_link_state == LINK_L1))
			x_cnt_ff <= '0;
		else
			x_cnt_ff <= x_cnt_ff + 16'h1;
	a_por_hold: assert property ($rose(i_rst_n) |-> !o_core_rst_n [*8])
		else $error("core reset released too early");
	a_pin_clk_stop: assert property (!i_ext_reset_n [*4] |-> !o_osc_en && !o_pll_en)
		else $error("clock sources run under pin reset");
	a_pin_standby: assert property (!i_ext_reset_n [*4] |-> o_standby && !o_core_rst_n)
		else $error("no standby under pin reset");
	a_pin_phy_off: assert property (!i_ext_reset_n [*4] |-> !o_phy_en && !o_dp_oe)
		else $error("transceiver active under pin reset");
	a_pin_abort: assert property (!i_ext_reset_n [*4] |-> o_xact_abort)
		else $error("transactions not aborted");
	a_pin_defaults: assert property (!i_ext_reset_n [*4] |-> o_addr == 7'h00
		&& o_config == 8'h00 && !o_configured && o_link_state == LINK_L0)
		else $error("state not default under pin reset");
	a_stable_wait: assert property ($rose(i_ext_reset_n) |-> !o_core_rst_n [*4])
		else $error("core reset released before clock stable");
	a_bus_rst_addr: assert property (i_bus_reset && o_core_rst_n |=> o_addr == DEFAULT_ADDR
		&& o_config == UNCONFIGURED && !o_configured)
		else $error("bus reset left address or configuration");
	a_bus_rst_wake: assert property (i_bus_reset && o_core_rst_n |-> ##2
		(o_link_state == LINK_L0 && !o_suspended))
		else $error("bus reset did not wake link");
	a_no_dn_fwd: assert property ($past(o_core_rst_n) && o_core_rst_n |-> !o_dn_reset)
		else $error("downstream reset while core runs");
	a_sleep_entry: assert property (s_cnt_ff < 16'h03E9)
		else $error("sleep entry too slow");
	a_sleep_exit: assert property (x_cnt_ff < 16'h1389)
		else $error("sleep exit too slow");
	cover property (i_bus_reset && o_suspended);
	cover property (o_link_state == LINK_L1 && !o_link_busy);
	cover property ($rose(i_ext_reset_n));
endmodule

bind hrlpc_top hrlpc_sva #(.POR_CNT(POR_CNT), .STABLE_CNT(STABLE_CNT),
	.L2_ENTRY_CNT(L2_ENTRY_CNT), .L2_EXIT_CNT(L2_EXIT_CNT)) chk_u (.*);

// ===== dv/hrlpc_host.sv
`timescale 1ns/1ps
module hrlpc_host
(
	input  wire logic  i_clk,
	output logic       o_bus_reset,
	output logic       o_set_addr,
	output logic [6:0] o_addr,
	output logic       o_set_config,
	output logic [7:0] o_config,
	output logic [2:0] o_lpm
);
	initial {o_bus_reset, o_set_addr, o_addr, o_set_config, o_config, o_lpm} = '0;
	// one-cycle strobe: bus reset, address, config, resume, l2, l1
	task automatic strobe(input logic [5:0] v);
		@(negedge i_clk);
		{o_bus_reset, o_set_addr, o_set_config, o_lpm} = v;
		@(negedge i_clk);
		{o_bus_reset, o_set_addr, o_set_config, o_lpm} = '0;
	endtask
	task automatic enumerate(input logic [6:0] a, input logic [7:0] c);
		@(negedge i_clk);
		o_addr = a;
		o_config = c;
		strobe(6'h10);
		strobe(6'h08);
		// data lines go stale once taken
		o_addr = ~a;
		o_config = ~c;
	endtask
endmodule

// ===== dv/hub_reset_and_link_power_control_bench.sv
`timescale 1ns/1ps
module hub_reset_and_link_power_control_bench;
	import hrlpc_pkg::*;
	logic i_clk, i_rst_n, i_ext_reset_n, i_bus_reset, i_set_addr, i_set_config;
	logic i_l1_req, i_l2_req, i_resume, o_osc_en, o_pll_en, o_core_rst_n, o_standby;
	logic o_phy_en, o_dp_oe, o_xact_abort, o_configured, o_suspended, o_dn_reset, o_link_busy;
	logic [6:0] i_addr, o_addr, a;
	logic [7:0] i_config, o_config, c, ctl;
	logic [5:0] v;
	hrlpc_link_type o_link_state;
	int err_total, n_tests, n;
	assign ctl = {1'b0, o_osc_en, o_pll_en, o_core_rst_n, o_standby, o_phy_en, o_dp_oe,
		o_xact_abort};
	hrlpc_top #(.L2_ENTRY_CNT(16), .L2_EXIT_CNT(12)) dut_u (.*);
	hrlpc_host host_u (.i_clk(i_clk), .o_bus_reset(i_bus_reset), .o_set_addr(i_set_addr),
		.o_addr(i_addr), .o_set_config(i_set_config), .o_config(i_config),
		.o_lpm({i_resume, i_l2_req, i_l1_req}));
	function automatic logic [7:0] ctl_exp(input logic up);
		return up ? 8'h76 : 8'h09;
	endfunction
	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			err_total++;
			$display("mismatch %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wait_up();
		for (n = 0; n < 2000 && o_core_rst_n !== 1'b1; n++)
			@(negedge i_clk);
		// transceiver and abort outputs follow the core reset one cycle later
		@(negedge i_clk);
	endtask
	task automatic wait_link(input hrlpc_link_type s, input int lim);
		for (n = 0; n < lim && !(o_link_state === s && o_link_busy === 1'b0); n++)
			@(negedge i_clk);
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		i_clk = 0;
		forever #5 i_clk = ~i_clk;
	end
	initial
	begin
		#200_000;
		err_total++;
		final_report();
	end
	initial
	begin
		i_rst_n = 0;
		i_ext_reset_n = 1;
		void'($urandom(47464));
		repeat (2) @(negedge i_clk);
		check("ctl in reset", ctl, ctl_exp(0));
		i_rst_n = 1;
		wait_up();
		check("por delay", n >= POR_CYCLES, 1);
		check("ctl up", ctl, ctl_exp(1));
		for (int i = 0; i < 4; i++)
		begin
			a = 7'($urandom);
			c = (i == 0) ? 8'h00 : 8'($urandom);
			host_u.enumerate(a, c);
			check("addr", o_addr, a);
			check("configured", o_configured, |c);
			host_u.strobe(6'h20);
			check("addr after bus reset", o_addr, 8'h00);
			check("config after bus reset", o_config | {7'h00, o_configured}, 8'h00);
			check("dn reset", o_dn_reset, 0);
		end
		host_u.strobe(6'h01);
		@(negedge i_clk);
		check("busy entering", o_link_busy, 1);
		wait_link(LINK_L1, 1100);
		check("sleep entry", n <= 1001, 1);
		host_u.strobe(6'h04);
		wait_link(LINK_L0, 5100);
		check("sleep exit", n <= 5001, 1);
		host_u.strobe(6'h03);
		wait_link(LINK_L2, 100);
		check("suspend entry", {n >= 16, o_suspended, o_link_state}, 8'h0E);
		host_u.strobe(6'h20);
		repeat (2) @(negedge i_clk);
		check("wake by bus reset", {o_suspended, o_link_state}, 8'h00);
		host_u.strobe(6'h02);
		wait_link(LINK_L2, 100);
		host_u.strobe(6'h04);
		wait_link(LINK_L0, 100);
		check("suspend exit", {n >= 12, o_link_state}, 8'h04);
		for (int i = 0; i < 40; i++)
		begin
			v = 6'($urandom);
			host_u.strobe(v);
			check("dn reset random", o_dn_reset, 0);
			if (v[5])
				check("addr random bus reset", o_addr, 8'h00);
		end
		host_u.enumerate(7'($urandom), 8'($urandom) | 8'h01);
		host_u.strobe(6'h01);
		repeat (5) @(negedge i_clk);
		i_ext_reset_n = 0;
		repeat (6) @(negedge i_clk);
		check("ctl pin reset", ctl, ctl_exp(0));
		check("state pin reset", {o_addr, o_configured} | o_config | o_link_state, 0);
		i_ext_reset_n = 1;
		wait_up();
		check("pin release", {n >= STABLE_CYCLES, ctl[6:0]}, 8'hF6);
		final_report();
	end
endmodule
